// file: hdl/t16b_timer.sv
// Contract
// - 16-bit registers accessed as two bytes
// - One shared high-byte latch for all
// - Low-byte write loads latch plus low byte
// - Count/capture low-byte read copies high byte to latch
// - Compare reads bypass and keep the latch
// - Write high first, read low first
// - Software masks interrupts around latch use
// - Latch survives low write, reusable
// - Counter high address goes to latch
// - Counter seen as two byte locations
// - Clock select picks prescaled or external tick
// - Clock select zero stops counter
// - Tick clears, increments or decrements counter
// - Flag bottom and top of count
// - CPU reaches counter whether running or not
// - CPU write beats count operations
// - Four-bit mode split over control A/B
// - Overflow flag per mode, raises interrupt
// - Force bits in C, top two mode bits in B
// - Bottom all zeros, max all ones
// - Top is fixed, compare A or capture
// Timer end: counter unit and byte register file.
// Assumes a prescaler strobe from outside; the external pin is synchronised here.
`timescale 1ns/10ps
module t16b_timer (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  t16b_bus_if.timer        bus,
  input  wire logic        prescale_tick,
  input  wire logic        ext_pin,
  input  wire logic        capture_strobe,
  output logic             at_bottom,
  output logic             at_top,
  output logic             match_a,
  output logic             match_b,
  output logic             force_a,
  output logic             force_b
);
  logic [15:0] timer_count;
  logic [15:0] compare_reg_a;
  logic [15:0] compare_reg_b;
  logic [15:0] capture_reg;
  logic [7:0]  high_latch;
  logic [7:0]  control_reg_a;
  logic [7:0]  control_reg_b;
  logic        overflow_flag;
  logic        count_down;
  logic [1:0]  ext_sync;
  logic        ext_last;
  logic        timer_tick;
  logic [3:0]  waveform_mode_field;
  logic [2:0]  clock_select_field;
  logic [15:0] top_value;
  logic        dual_slope;
  logic [15:0] next_count;
  logic        next_down;
  logic        ovf_event;
  logic        wr_low;
  logic        flag_clear;

  assign waveform_mode_field = {
    control_reg_b[t16b_pkg::WGM_HI_POS +: 2],
    control_reg_a[t16b_pkg::WGM_LO_POS +: 2]};
  assign clock_select_field = control_reg_b[t16b_pkg::CS_POS +: 3];
  assign dual_slope = waveform_mode_field inside {
    t16b_pkg::WGM_PC8, t16b_pkg::WGM_PC9, t16b_pkg::WGM_PC10,
    t16b_pkg::WGM_PFC_ICR, t16b_pkg::WGM_PFC_OCR,
    t16b_pkg::WGM_PC_ICR, t16b_pkg::WGM_PC_OCR};

  // External pin crosses two flops before edge detect
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext_sync <= 2'b00;
      ext_last <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[0], ext_pin};
      ext_last <= ext_sync[1];
    end
  end

  always_comb begin
    case (clock_select_field)
      t16b_pkg::CS_STOPPED:  timer_tick = 1'b0;
      t16b_pkg::CS_EXTERNAL: timer_tick = ext_last & ~ext_sync[1];
      3'h7:                  timer_tick = ~ext_last & ext_sync[1];
      default:               timer_tick = prescale_tick;
    endcase
  end

  always_comb begin
    case (waveform_mode_field)
      t16b_pkg::WGM_PC8, t16b_pkg::WGM_FAST8:   top_value = t16b_pkg::TOP_8BIT;
      t16b_pkg::WGM_PC9, t16b_pkg::WGM_FAST9:   top_value = t16b_pkg::TOP_9BIT;
      t16b_pkg::WGM_PC10, t16b_pkg::WGM_FAST10: top_value = t16b_pkg::TOP_10BIT;
      t16b_pkg::WGM_CTC_OCR, t16b_pkg::WGM_PFC_OCR,
      t16b_pkg::WGM_PC_OCR, t16b_pkg::WGM_FAST_OCR: top_value = compare_reg_a;
      t16b_pkg::WGM_PFC_ICR, t16b_pkg::WGM_PC_ICR,
      t16b_pkg::WGM_CTC_ICR, t16b_pkg::WGM_FAST_ICR: top_value = capture_reg;
      default: top_value = t16b_pkg::COUNT_MAX;
    endcase
  end

  // Count sequence and overflow point per mode
  always_comb begin
    next_count = timer_count;
    next_down  = count_down;
    ovf_event  = 1'b0;
    if (timer_tick) begin
      if (dual_slope) begin
        if (count_down && timer_count == t16b_pkg::COUNT_BOTTOM) begin
          next_down  = 1'b0;
          next_count = timer_count + t16b_pkg::WORD_ONE;
          ovf_event  = 1'b1;
        end else if (!count_down && timer_count >= top_value) begin
          next_down  = 1'b1;
          next_count = timer_count - t16b_pkg::WORD_ONE;
        end else if (count_down) begin
          next_count = timer_count - t16b_pkg::WORD_ONE;
        end else begin
          next_count = timer_count + t16b_pkg::WORD_ONE;
        end
      end else if (timer_count == top_value) begin
        next_count = t16b_pkg::WORD_ZERO;
        next_down  = 1'b0;
        // CTC overflows only at max, fast and normal at top
        ovf_event  = (top_value == t16b_pkg::COUNT_MAX) ||
                     !(waveform_mode_field inside
                       {t16b_pkg::WGM_CTC_OCR, t16b_pkg::WGM_CTC_ICR});
      end else begin
        next_count = timer_count + t16b_pkg::WORD_ONE;
        next_down  = 1'b0;
      end
    end
  end

  assign wr_low = bus.wr_en && (bus.sel == t16b_pkg::SEL_COUNT_LOW);
  assign flag_clear = bus.wr_en && (bus.sel == t16b_pkg::SEL_FLAGS) &&
                      bus.wdata[t16b_pkg::OVF_POS];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timer_count <= t16b_pkg::WORD_ZERO;
      count_down  <= 1'b0;
    end else if (wr_low) begin
      timer_count <= {high_latch, bus.wdata};
    end else begin
      timer_count <= next_count;
      count_down  <= next_down;
    end
  end

  // Shared high-byte latch
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      high_latch <= t16b_pkg::BYTE_ZERO;
    end else if (bus.wr_en) begin
      case (bus.sel)
        t16b_pkg::SEL_COUNT_HIGH, t16b_pkg::SEL_CMPA_HIGH,
        t16b_pkg::SEL_CMPB_HIGH, t16b_pkg::SEL_CAPT_HIGH:
          high_latch <= bus.wdata;
        default: high_latch <= high_latch;
      endcase
    end else if (bus.rd_en) begin
      case (bus.sel)
        t16b_pkg::SEL_COUNT_LOW: high_latch <= timer_count[15:8];
        t16b_pkg::SEL_CAPT_LOW:  high_latch <= capture_reg[15:8];
        default: high_latch <= high_latch;
      endcase
    end
  end

  // Compare and capture registers, 16 bits wide in one cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      compare_reg_a <= t16b_pkg::WORD_ZERO;
      compare_reg_b <= t16b_pkg::WORD_ZERO;
      capture_reg   <= t16b_pkg::WORD_ZERO;
    end else begin
      if (bus.wr_en && bus.sel == t16b_pkg::SEL_CMPA_LOW)
        compare_reg_a <= {high_latch, bus.wdata};
      if (bus.wr_en && bus.sel == t16b_pkg::SEL_CMPB_LOW)
        compare_reg_b <= {high_latch, bus.wdata};
      if (bus.wr_en && bus.sel == t16b_pkg::SEL_CAPT_LOW)
        capture_reg <= {high_latch, bus.wdata};
      else if (capture_strobe)
        capture_reg <= timer_count;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      control_reg_a <= t16b_pkg::BYTE_ZERO;
      control_reg_b <= t16b_pkg::BYTE_ZERO;
      force_a       <= 1'b0;
      force_b       <= 1'b0;
    end else begin
      if (bus.wr_en && bus.sel == t16b_pkg::SEL_CTRL_A)
        control_reg_a <= bus.wdata;
      if (bus.wr_en && bus.sel == t16b_pkg::SEL_CTRL_B)
        control_reg_b <= bus.wdata;
      // Force bits are strobes, never stored
      force_a <= bus.wr_en && bus.sel == t16b_pkg::SEL_CTRL_C &&
                 bus.wdata[t16b_pkg::FOCA_POS];
      force_b <= bus.wr_en && bus.sel == t16b_pkg::SEL_CTRL_C &&
                 bus.wdata[t16b_pkg::FOCB_POS];
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      overflow_flag <= 1'b0;
    end else if (ovf_event && !wr_low) begin
      overflow_flag <= 1'b1;
    end else if (bus.wr_en && bus.sel == t16b_pkg::SEL_FLAGS &&
                 bus.wdata[t16b_pkg::OVF_POS]) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      at_bottom   <= 1'b0;
      at_top      <= 1'b0;
      match_a     <= 1'b0;
      match_b     <= 1'b0;
      bus.ovf_irq <= 1'b0;
    end else begin
      at_bottom   <= next_count == t16b_pkg::COUNT_BOTTOM;
      at_top      <= next_count == top_value;
      match_a     <= next_count == compare_reg_a;
      match_b     <= next_count == compare_reg_b;
      // Mirrors the flag, so a clear drops the request at once
      bus.ovf_irq <= (ovf_event && !wr_low) ||
                     (overflow_flag && !flag_clear);
    end
  end

  // Byte read mux; high count/capture reads return the latch
  always_comb begin
    case (bus.sel)
      t16b_pkg::SEL_COUNT_LOW:  bus.rdata = timer_count[7:0];
      t16b_pkg::SEL_COUNT_HIGH: bus.rdata = high_latch;
      t16b_pkg::SEL_CMPA_LOW:   bus.rdata = compare_reg_a[7:0];
      t16b_pkg::SEL_CMPA_HIGH:  bus.rdata = compare_reg_a[15:8];
      t16b_pkg::SEL_CMPB_LOW:   bus.rdata = compare_reg_b[7:0];
      t16b_pkg::SEL_CMPB_HIGH:  bus.rdata = compare_reg_b[15:8];
      t16b_pkg::SEL_CAPT_LOW:   bus.rdata = capture_reg[7:0];
      t16b_pkg::SEL_CAPT_HIGH:  bus.rdata = high_latch;
      t16b_pkg::SEL_CTRL_A:     bus.rdata = control_reg_a;
      t16b_pkg::SEL_CTRL_B:     bus.rdata = control_reg_b;
      t16b_pkg::SEL_FLAGS:      bus.rdata = {7'h00, overflow_flag};
      default:                  bus.rdata = t16b_pkg::BYTE_ZERO;
    endcase
  end
endmodule : t16b_timer

// file: hdl/t16b_pkg.sv
// Package for the 16-bit timer byte access block.
// Assumes one system clock shared by the CPU end and the timer end.
package t16b_pkg;
  // Byte register selects on the CPU bus
  localparam logic [3:0] SEL_COUNT_LOW    = 4'h0;
  localparam logic [3:0] SEL_COUNT_HIGH   = 4'h1;
  localparam logic [3:0] SEL_CMPA_LOW     = 4'h2;
  localparam logic [3:0] SEL_CMPA_HIGH    = 4'h3;
  localparam logic [3:0] SEL_CMPB_LOW     = 4'h4;
  localparam logic [3:0] SEL_CMPB_HIGH    = 4'h5;
  localparam logic [3:0] SEL_CAPT_LOW     = 4'h6;
  localparam logic [3:0] SEL_CAPT_HIGH    = 4'h7;
  localparam logic [3:0] SEL_CTRL_A       = 4'h8;
  localparam logic [3:0] SEL_CTRL_B       = 4'h9;
  localparam logic [3:0] SEL_CTRL_C       = 4'hA;
  localparam logic [3:0] SEL_FLAGS        = 4'hB;
  // Field positions
  localparam int WGM_LO_POS   = 0;  // control_reg_a bits 1:0
  localparam int WGM_HI_POS   = 3;  // control_reg_b bits 4:3
  localparam int CS_POS       = 0;  // control_reg_b bits 2:0
  localparam int FOCA_POS     = 7;  // control_reg_c
  localparam int FOCB_POS     = 6;
  localparam int OVF_POS      = 0;  // flags register
  // Count constants
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT     = 16'h00FF;
  localparam logic [15:0] TOP_9BIT     = 16'h01FF;
  localparam logic [15:0] TOP_10BIT    = 16'h03FF;
  localparam logic [2:0]  CS_STOPPED   = 3'h0;
  localparam logic [2:0]  CS_EXTERNAL  = 3'h6;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [15:0] WORD_ZERO    = 16'h0000;
  localparam logic [15:0] WORD_ONE     = 16'h0001;
  // Waveform mode codes
  localparam logic [3:0] WGM_NORMAL     = 4'h0;
  localparam logic [3:0] WGM_PC8        = 4'h1;
  localparam logic [3:0] WGM_PC9        = 4'h2;
  localparam logic [3:0] WGM_PC10       = 4'h3;
  localparam logic [3:0] WGM_CTC_OCR    = 4'h4;
  localparam logic [3:0] WGM_FAST8      = 4'h5;
  localparam logic [3:0] WGM_FAST9      = 4'h6;
  localparam logic [3:0] WGM_FAST10     = 4'h7;
  localparam logic [3:0] WGM_PFC_ICR    = 4'h8;
  localparam logic [3:0] WGM_PFC_OCR    = 4'h9;
  localparam logic [3:0] WGM_PC_ICR     = 4'hA;
  localparam logic [3:0] WGM_PC_OCR     = 4'hB;
  localparam logic [3:0] WGM_CTC_ICR    = 4'hC;
  localparam logic [3:0] WGM_FAST_ICR   = 4'hE;
  localparam logic [3:0] WGM_FAST_OCR   = 4'hF;
  // CPU end sequencer states
  typedef enum logic [3:0] {
    T16B_IDLE  = 4'b0001,
    T16B_FIRST = 4'b0010,
    T16B_SECND = 4'b0100,
    T16B_DONE  = 4'b1000
  } t16b_state_type;
endpackage : t16b_pkg

// file: hdl/t16b_bus_if.sv
// Byte bus between the CPU end and the timer end.
// Assumes both ends run on ref_clk; read data is combinational.
`timescale 1ns/10ps
interface t16b_bus_if;
  logic       wr_en;
  logic       rd_en;
  logic [3:0] sel;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       ovf_irq;
  modport timer (input wr_en, input rd_en, input sel, input wdata,
                 output rdata, output ovf_irq);
  modport cpu   (output wr_en, output rd_en, output sel, output wdata,
                 input rdata, input ovf_irq);
endinterface : t16b_bus_if

// file: hdl/t16b_cpu.sv
// CPU end: turns one 16-bit user request into two byte operations.
// Assumes the timer end answers reads combinationally in the same cycle.
`timescale 1ns/10ps
module t16b_cpu (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  t16b_bus_if.cpu          bus,
  input  wire logic        req,
  input  wire logic        req_write,
  input  wire logic        req_wide,
  input  wire logic [3:0]  req_sel,
  input  wire logic [15:0] req_wdata,
  output logic             busy,
  output logic             done,
  output logic [15:0]      rdata,
  output logic             irq
);
  t16b_pkg::t16b_state_type state;
  logic        is_write;
  logic        is_wide;
  logic [3:0]  low_sel;
  logic [15:0] wdata_hold;

  // Requests are taken only when idle, so the pair stays atomic
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state      <= t16b_pkg::T16B_IDLE;
      is_write   <= 1'b0;
      is_wide    <= 1'b0;
      low_sel    <= t16b_pkg::SEL_COUNT_LOW;
      wdata_hold <= t16b_pkg::WORD_ZERO;
    end else begin
      case (state)
        t16b_pkg::T16B_IDLE: begin
          if (req) begin
            state      <= t16b_pkg::T16B_FIRST;
            is_write   <= req_write;
            is_wide    <= req_wide;
            low_sel    <= req_sel;
            wdata_hold <= req_wdata;
          end
        end
        t16b_pkg::T16B_FIRST:
          state <= is_wide ? t16b_pkg::T16B_SECND : t16b_pkg::T16B_DONE;
        t16b_pkg::T16B_SECND: state <= t16b_pkg::T16B_DONE;
        t16b_pkg::T16B_DONE:  state <= t16b_pkg::T16B_IDLE;
        default:              state <= t16b_pkg::T16B_IDLE;
      endcase
    end
  end

  // Byte bus drive; wide write goes high then low, read low then high
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus.wr_en <= 1'b0;
      bus.rd_en <= 1'b0;
      bus.sel   <= t16b_pkg::SEL_COUNT_LOW;
      bus.wdata <= t16b_pkg::BYTE_ZERO;
    end else begin
      bus.wr_en <= 1'b0;
      bus.rd_en <= 1'b0;
      if (state == t16b_pkg::T16B_IDLE && req) begin
        bus.wr_en <= req_write;
        bus.rd_en <= !req_write;
        bus.sel   <= (req_wide && req_write) ? (req_sel | 4'h1) : req_sel;
        bus.wdata <= (req_wide && req_write) ? req_wdata[15:8]
                                              : req_wdata[7:0];
      end else if (state == t16b_pkg::T16B_FIRST && is_wide) begin
        bus.wr_en <= is_write;
        bus.rd_en <= !is_write;
        bus.sel   <= is_write ? low_sel : (low_sel | 4'h1);
        bus.wdata <= wdata_hold[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= t16b_pkg::WORD_ZERO;
      busy  <= 1'b0;
      done  <= 1'b0;
      irq   <= 1'b0;
    end else begin
      if (bus.rd_en && state == t16b_pkg::T16B_FIRST)
        rdata <= {8'h00, bus.rdata};
      else if (bus.rd_en && state == t16b_pkg::T16B_SECND)
        rdata <= {bus.rdata, rdata[7:0]};
      busy <= (state == t16b_pkg::T16B_IDLE) ? req
                                             : (state != t16b_pkg::T16B_DONE);
      done <= state == t16b_pkg::T16B_SECND ||
              (state == t16b_pkg::T16B_FIRST && !is_wide);
      // Software-level masking: one request in flight at a time
      irq  <= bus.ovf_irq;
    end
  end
endmodule : t16b_cpu

// file: verification/t16b_bus_assertions.sv
// Checker on the byte bus between the CPU end and the timer end.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/10ps
module t16b_bus_assertions (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [3:0] sel,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       ovf_irq
);
  logic [7:0]  latch_q;
  logic        latch_ok;
  logic [15:0] cmpa_q;
  logic        cmpa_ok;
  logic [7:0]  ctrla_q;
  logic [7:0]  ctrlb_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Latch content is lost track of once a low read copies the count
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      latch_q  <= 8'h00;
      latch_ok <= 1'b1;
    end else if (wr_en && sel[0] && sel <= t16b_pkg::SEL_CAPT_HIGH) begin
      latch_q  <= wdata;
      latch_ok <= 1'b1;
    end else if (rd_en && (sel == t16b_pkg::SEL_COUNT_LOW ||
                           sel == t16b_pkg::SEL_CAPT_LOW)) begin
      latch_ok <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmpa_q  <= 16'h0000;
      cmpa_ok <= 1'b1;
    end else if (wr_en && sel == t16b_pkg::SEL_CMPA_LOW) begin
      cmpa_q  <= {latch_q, wdata};
      cmpa_ok <= latch_ok;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrla_q <= 8'h00;
      ctrlb_q <= 8'h00;
    end else if (wr_en && sel == t16b_pkg::SEL_CTRL_A) begin
      ctrla_q <= wdata;
    end else if (wr_en && sel == t16b_pkg::SEL_CTRL_B) begin
      ctrlb_q <= wdata;
    end
  end

  a_reset_clears_flag: assert property (disable iff (1'b0)
    rst |=> !ovf_irq) else $error("overflow flag set after reset");
  a_high_reads_latch: assert property (
    rd_en && latch_ok && (sel == t16b_pkg::SEL_COUNT_HIGH ||
      sel == t16b_pkg::SEL_CAPT_HIGH) |-> rdata == latch_q)
    else $error("high byte read does not return the latch");
  a_cmp_high_direct: assert property (
    rd_en && cmpa_ok && sel == t16b_pkg::SEL_CMPA_HIGH |-> rdata == cmpa_q[15:8])
    else $error("compare high byte read wrong");
  a_cmp_low_pair: assert property (
    rd_en && cmpa_ok && sel == t16b_pkg::SEL_CMPA_LOW |-> rdata == cmpa_q[7:0])
    else $error("compare low byte read wrong");
  a_unmapped_reads_zero: assert property (
    rd_en && sel > t16b_pkg::SEL_FLAGS |-> rdata == 8'h00)
    else $error("unmapped select read not zero");
  a_flag_write_clear: assert property (
    wr_en && sel == t16b_pkg::SEL_FLAGS && wdata[0] ##1 !wr_en [*2]
    |-> !ovf_irq) else $error("overflow flag not cleared");
  a_flag_sticky: assert property (
    ovf_irq && !(wr_en && sel == t16b_pkg::SEL_FLAGS) |=> ovf_irq)
    else $error("overflow flag dropped without clear");
  a_mode_low_back: assert property (
    rd_en && sel == t16b_pkg::SEL_CTRL_A |-> rdata[1:0] == ctrla_q[1:0])
    else $error("mode bits in control A wrong");
  a_mode_high_back: assert property (
    rd_en && sel == t16b_pkg::SEL_CTRL_B |-> rdata[4:0] == ctrlb_q[4:0])
    else $error("control B fields wrong");
  a_one_byte_op: assert property (
    !(wr_en && rd_en)) else $error("read and write in one cycle");
endmodule : t16b_bus_assertions

// file: verification/timer16_byte_access_counter_test.sv
// Testbench: CPU end and timer end joined by the byte bus.
// Assumes narrow requests move one byte in bits 7:0.
`timescale 1ns/10ps
module timer16_byte_access_counter_test;
  logic        ref_clk, rst, req, req_write, req_wide;
  logic        busy, done, irq, prescale_tick, ext_pin;
  logic        at_bottom, at_top, match_a, match_b, force_a, force_b;
  logic        cap_stb;
  logic [3:0]  req_sel;
  logic [15:0] req_wdata, rdata, q;
  int          bad_count, tests_run;

  t16b_bus_if bus_link ();
  t16b_cpu u_t16b_cpu (.ref_clk(ref_clk), .rst(rst), .bus(bus_link),
    .req(req), .req_write(req_write), .req_wide(req_wide),
    .req_sel(req_sel), .req_wdata(req_wdata), .busy(busy), .done(done),
    .rdata(rdata), .irq(irq));
  t16b_timer u_t16b_timer (.ref_clk(ref_clk), .rst(rst), .bus(bus_link),
    .prescale_tick(prescale_tick), .ext_pin(ext_pin),
    .capture_strobe(cap_stb), .at_bottom(at_bottom), .at_top(at_top),
    .match_a(match_a), .match_b(match_b), .force_a(force_a),
    .force_b(force_b));
  t16b_bus_assertions u_chk (.ref_clk(ref_clk), .rst(rst),
    .wr_en(bus_link.wr_en), .rd_en(bus_link.rd_en), .sel(bus_link.sel),
    .wdata(bus_link.wdata), .rdata(bus_link.rdata),
    .ovf_irq(bus_link.ovf_irq));

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Bounded wait on done so a dead CPU end cannot hang the run
  task automatic op(input logic wr, wide, input logic [3:0] s,
                    input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    req       <= 1'b1;
    req_write <= wr;
    req_wide  <= wide;
    req_sel   <= s;
    req_wdata <= d;
    @(posedge ref_clk);
    req <= 1'b0;
    #1;
    chk("busy", {15'h0000, busy}, 16'h0001);
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 10);
    if (n >= 10) chk("done", 16'h0000, 16'h0001);
    q = rdata;
  endtask : op

  task automatic wr(input logic wide, input logic [3:0] s,
                    input logic [15:0] d);
    op(1'b1, wide, s, d);
  endtask : wr

  task automatic rd(input logic wide, input logic [3:0] s,
                    input logic [15:0] e, input string nm);
    op(1'b0, wide, s, 16'h0000);
    chk(nm, wide ? q : {8'h00, q[7:0]}, e);
  endtask : rd

  task automatic tick(input int n);
    @(posedge ref_clk);
    prescale_tick <= 1'b1;
    repeat (n) @(posedge ref_clk);
    prescale_tick <= 1'b0;
  endtask : tick

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    req = 1'b0;
    req_write = 1'b0;
    req_wide = 1'b0;
    req_sel = 4'h0;
    req_wdata = 16'h0000;
    prescale_tick = 1'b0;
    ext_pin = 1'b0;
    cap_stb = 1'b0;
    bad_count = 0;
    tests_run = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd(1'b1, t16b_pkg::SEL_COUNT_LOW, 16'h0000, "count");
    rd(1'b0, t16b_pkg::SEL_CTRL_B, 16'h0000, "ctrl_b");
    rd(1'b0, t16b_pkg::SEL_FLAGS, 16'h0000, "flags");
    chk("at_bottom", {15'h0000, at_bottom}, 16'h0001);
    $display("test reset done");
    wr(1'b1, t16b_pkg::SEL_COUNT_LOW, 16'h01FF);
    rd(1'b1, t16b_pkg::SEL_COUNT_LOW, 16'h01FF, "count");
    tick(5);
    rd(1'b1, t16b_pkg::SEL_COUNT_LOW, 16'h01FF, "count");
    rd(1'b0, 4'hC, 16'h0000, "unmapped");
    wr(1'b0, t16b_pkg::SEL_CTRL_C, 16'h0080);
    chk("force_a", {14'h0000, force_a, force_b}, 16'h0002);
    wr(1'b0, t16b_pkg::SEL_CTRL_C, 16'h0040);
    chk("force_b", {14'h0000, force_a, force_b}, 16'h0001);
    $display("test word access done");
    wr(1'b1, t16b_pkg::SEL_CMPA_LOW, 16'h1234);
    wr(1'b1, t16b_pkg::SEL_COUNT_LOW, 16'h1234);
    wr(1'b0, t16b_pkg::SEL_CMPB_LOW, 16'h0056);
    chk("match_a", {15'h0000, match_a}, 16'h0001);
    chk("match_b", {15'h0000, match_b}, 16'h0000);
    rd(1'b1, t16b_pkg::SEL_CMPB_LOW, 16'h1256, "cmp_b");
    wr(1'b0, t16b_pkg::SEL_COUNT_HIGH, 16'h00AB);
    rd(1'b1, t16b_pkg::SEL_CMPA_LOW, 16'h1234, "cmp_a");
    rd(1'b0, t16b_pkg::SEL_COUNT_HIGH, 16'h00AB, "latch");
    wr(1'b0, t16b_pkg::SEL_COUNT_LOW, 16'h0000);
    rd(1'b1, t16b_pkg::SEL_COUNT_LOW, 16'hAB00, "count");
    $display("test shared latch done");
    wr(1'b1, t16b_pkg::SEL_COUNT_LOW, 16'h0010);
    wr(1'b0, t16b_pkg::SEL_CTRL_B, 16'h0001);
    rd(1'b0, t16b_pkg::SEL_CTRL_B, 16'h0001, "ctrl_b");
    tick(5);
    wr(1'b0, t16b_pkg::SEL_CTRL_B, 16'h0000);
    rd(1'b1, t16b_pkg::SEL_COUNT_LOW, 16'h0015, "count");
    wr(1'b1, t16b_pkg::SEL_COUNT_LOW, 16'h00FD);
    wr(1'b0, t16b_pkg::SEL_CTRL_A, 16'h0001);
    rd(1'b0, t16b_pkg::SEL_CTRL_A, 16'h0001, "ctrl_a");
    wr(1'b0, t16b_pkg::SEL_CTRL_B, 16'h0001);
    tick(2);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("at_top", {15'h0000, at_top}, 16'h0001);
    tick(2);
    wr(1'b0, t16b_pkg::SEL_CTRL_B, 16'h0000);
    rd(1'b1, t16b_pkg::SEL_COUNT_LOW, 16'h00FD, "down");
    wr(1'b0, t16b_pkg::SEL_CTRL_A, 16'h0000);
    $display("test counting done");
    // Tick held high: the low write must win over that cycle's count
    wr(1'b0, t16b_pkg::SEL_CTRL_B, 16'h0001);
    @(posedge ref_clk);
    prescale_tick <= 1'b1;
    wr(1'b1, t16b_pkg::SEL_COUNT_LOW, 16'h2000);
    rd(1'b1, t16b_pkg::SEL_COUNT_LOW, 16'h2002, "run");
    @(posedge ref_clk);
    prescale_tick <= 1'b0;
    wr(1'b0, t16b_pkg::SEL_CTRL_B, 16'h0000);
    $display("test write priority done");
    wr(1'b1, t16b_pkg::SEL_COUNT_LOW, 16'hFFFE);
    wr(1'b0, t16b_pkg::SEL_CTRL_B, 16'h0001);
    tick(2);
    wr(1'b0, t16b_pkg::SEL_CTRL_B, 16'h0000);
    chk("at_bottom", {15'h0000, at_bottom}, 16'h0001);
    chk("irq", {15'h0000, irq}, 16'h0001);
    rd(1'b0, t16b_pkg::SEL_FLAGS, 16'h0001, "flags");
    wr(1'b0, t16b_pkg::SEL_FLAGS, 16'h0001);
    rd(1'b0, t16b_pkg::SEL_FLAGS, 16'h0000, "flags");
    $display("test overflow done");
    // Both edge codes; each level held past the two-flop sync
    for (int cs = 6; cs < 8; cs++) begin
      wr(1'b1, t16b_pkg::SEL_COUNT_LOW, 16'h0000);
      wr(1'b0, t16b_pkg::SEL_CTRL_B, 16'(cs));
      repeat (3) begin
        repeat (4) @(posedge ref_clk);
        ext_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        ext_pin <= 1'b0;
      end
      repeat (6) @(posedge ref_clk);
      wr(1'b0, t16b_pkg::SEL_CTRL_B, 16'h0000);
      rd(1'b1, t16b_pkg::SEL_COUNT_LOW, 16'h0003, "ext");
    end
    $display("test external tick done");
    @(posedge ref_clk);
    cap_stb <= 1'b1;
    @(posedge ref_clk);
    cap_stb <= 1'b0;
    rd(1'b1, t16b_pkg::SEL_CAPT_LOW, 16'h0003, "capture");
    wr(1'b1, t16b_pkg::SEL_CAPT_LOW, 16'h5678);
    rd(1'b1, t16b_pkg::SEL_CAPT_LOW, 16'h5678, "capture");
    $display("test capture done");
    summarize();
  end
endmodule : timer16_byte_access_counter_test
